// ---- bsctu_top.sv ----
// Bit set/clear/test execution unit with its data memory
`timescale 1ns/1ps
module bsctu_top (
   input wire logic clk, // Instruction clock, 20 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire logic instr_valid, // Fetched instruction presented this cycle
   input wire bsctu_pkg::bsctu_op_t op, // Decoded operation
   input wire logic [bsctu_pkg::ADDR_W-1:0] addr, // Register address 00h..FFh
   input wire logic [bsctu_pkg::BIT_W-1:0] bit_sel, // Bit position 0..7
   output logic instr_done, // Pulse: operation completed
   output logic skip_taken, // Pulse: test decided to skip
   output logic squashing, // Level: current fetched instruction is discarded
   output logic wr_en, // Pulse: write-back of modified byte
   output logic [bsctu_pkg::ADDR_W-1:0] wr_addr, // Address of last write-back
   output logic [bsctu_pkg::DATA_W-1:0] wr_data // Data of last write-back
);
   // ****************************************
   // Operand fetch
   // ****************************************
   // The instruction is held one cycle while the memory read completes, so each
   // instruction takes a read phase then an execute phase; the phase pair is one
   // instruction cycle as seen from the unit.
   logic phase;
   bsctu_pkg::bsctu_op_t op_q;
   logic [bsctu_pkg::ADDR_W-1:0] addr_q;
   logic [bsctu_pkg::BIT_W-1:0] bit_q;
   logic [bsctu_pkg::DATA_W-1:0] rdata;
   logic [bsctu_pkg::DATA_W-1:0] mask;
   logic [bsctu_pkg::DATA_W-1:0] next_byte;
   logic mem_we;
   logic tested_bit;
   bsctu_pkg::bsctu_state_t state;

   // Read uses the live address at the accept edge; the previous write-back lands one
   // edge earlier, so a read of the same byte never sees stale data
   bsctu_mem u_mem (
      .clk(clk),
      .raddr(addr),
      .rdata(rdata),
      .we(mem_we),
      .waddr(addr_q),
      .wdata(next_byte)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= 1'b0;
         op_q <= bsctu_pkg::bsctu_no_operation;
         addr_q <= '0;
         bit_q <= '0;
      end else if (instr_valid && !phase) begin
         phase <= 1'b1;
         // Discarded instruction becomes a no-operation
         op_q <= (state == bsctu_pkg::BSCTU_SKIP) ? bsctu_pkg::bsctu_no_operation : op;
         addr_q <= addr;
         bit_q <= bit_sel;
      end else begin
         phase <= 1'b0;
      end
   end

   // ****************************************
   // Execute
   // ****************************************
   assign mask = bsctu_pkg::ONE_HOT_BASE << bit_q;
   assign tested_bit = |(rdata & mask);

   always_comb begin
      next_byte = rdata;
      mem_we = 1'b0;
      if (phase) begin
         case (op_q)
            bsctu_pkg::bsctu_bit_clear_op: begin
               next_byte = rdata & ~mask;
               mem_we = 1'b1;
            end
            bsctu_pkg::bsctu_bit_set_op: begin
               next_byte = rdata | mask;
               mem_we = 1'b1;
            end
            default: begin
               next_byte = rdata;
               mem_we = 1'b0;
            end
         endcase
      end
   end

   logic skip_now;
   always_comb begin
      skip_now = 1'b0;
      if (phase) begin
         case (op_q)
            bsctu_pkg::bsctu_test_skip_if_zero_op: skip_now = !tested_bit;
            bsctu_pkg::bsctu_test_skip_if_one_op: skip_now = tested_bit;
            default: skip_now = 1'b0;
         endcase
      end
   end

   // Skip state covers the next instruction slot, giving a taken test two cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= bsctu_pkg::BSCTU_EXEC;
      end else begin
         case (state)
            bsctu_pkg::BSCTU_EXEC: if (skip_now) state <= bsctu_pkg::BSCTU_SKIP;
            bsctu_pkg::BSCTU_SKIP: if (phase) state <= bsctu_pkg::BSCTU_EXEC;
            default: state <= bsctu_pkg::BSCTU_EXEC;
         endcase
      end
   end

   assign squashing = (state == bsctu_pkg::BSCTU_SKIP);
   assign instr_done = phase;
   assign skip_taken = skip_now;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_en <= 1'b0;
         wr_addr <= '0;
         wr_data <= bsctu_pkg::DATA_RESET;
      end else begin
         wr_en <= mem_we;
         if (mem_we) begin
            wr_addr <= addr_q;
            wr_data <= next_byte;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_clr;
      @(posedge clk) disable iff (rst)
         (phase && op_q == bsctu_pkg::bsctu_bit_clear_op) |=> (wr_en && wr_data == ($past(rdata) & ~$past(mask)));
   endproperty
   a_clr: assert property (p_clr) else $error("bit clear wrong");

   property p_set;
      @(posedge clk) disable iff (rst)
         (phase && op_q == bsctu_pkg::bsctu_bit_set_op) |=> (wr_en && wr_data == ($past(rdata) | $past(mask)));
   endproperty
   a_set: assert property (p_set) else $error("bit set wrong");

   property p_tz;
      @(posedge clk) disable iff (rst)
         (phase && op_q == bsctu_pkg::bsctu_test_skip_if_zero_op) |-> (skip_taken == !rdata[bit_q]);
   endproperty
   a_tz: assert property (p_tz) else $error("skip if zero wrong");

   property p_to;
      @(posedge clk) disable iff (rst)
         (phase && op_q == bsctu_pkg::bsctu_test_skip_if_one_op) |-> (skip_taken == rdata[bit_q]);
   endproperty
   a_to: assert property (p_to) else $error("skip if one wrong");

   property p_squash;
      @(posedge clk) disable iff (rst)
         (squashing && phase) |-> !mem_we && !skip_now;
   endproperty
   a_squash: assert property (p_squash) else $error("discarded instruction had effect");

   property p_two;
      @(posedge clk) disable iff (rst)
         skip_taken |=> squashing;
   endproperty
   a_two: assert property (p_two) else $error("taken skip did not add a cycle");

   property p_one;
      @(posedge clk) disable iff (rst)
         (phase && !skip_taken && !squashing) |=> !squashing;
   endproperty
   a_one: assert property (p_one) else $error("untaken test added a cycle");

   property p_rmw;
      @(posedge clk) disable iff (rst)
         mem_we |=> (wr_addr == $past(addr_q) && (wr_data & ~$past(mask)) == ($past(rdata) & ~$past(mask)));
   endproperty
   a_rmw: assert property (p_rmw) else $error("other bits changed");

   // Bit-level checks, independent of the mask arithmetic used above
   property p_clr_bit;
      @(posedge clk) disable iff (rst)
         (phase && op_q == bsctu_pkg::bsctu_bit_clear_op) |=> !wr_data[$past(bit_q)];
   endproperty
   a_clr_bit: assert property (p_clr_bit) else $error("cleared bit not zero");

   property p_set_bit;
      @(posedge clk) disable iff (rst)
         (phase && op_q == bsctu_pkg::bsctu_bit_set_op) |=> wr_data[$past(bit_q)];
   endproperty
   a_set_bit: assert property (p_set_bit) else $error("set bit not one");

   // A test only reads; it must never write its byte back
   property p_test_nowr;
      @(posedge clk) disable iff (rst)
         (phase && (op_q == bsctu_pkg::bsctu_test_skip_if_zero_op || op_q == bsctu_pkg::bsctu_test_skip_if_one_op))
            |-> !mem_we;
   endproperty
   a_test_nowr: assert property (p_test_nowr) else $error("bit test wrote its byte");

   property p_squash_nowr;
      @(posedge clk) disable iff (rst)
         (squashing && phase) |=> !wr_en;
   endproperty
   a_squash_nowr: assert property (p_squash_nowr) else $error("discarded slot wrote back");

   // Squash window must close after exactly one slot, so a taken test costs two cycles, not three
   property p_squash_end;
      @(posedge clk) disable iff (rst)
         (squashing && phase) |=> !squashing;
   endproperty
   a_squash_end: assert property (p_squash_end) else $error("squash window too long");

   property p_done_pulse;
      @(posedge clk) disable iff (rst)
         instr_done |=> !instr_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("execute phase longer than one clock");

   property p_accept;
      @(posedge clk) disable iff (rst)
         (!phase && instr_valid) |=> instr_done;
   endproperty
   a_accept: assert property (p_accept) else $error("accepted instruction not executed");

   property p_wr_pulse;
      @(posedge clk) disable iff (rst)
         wr_en |=> !wr_en;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write-back longer than one clock");

   property p_wr_hold;
      @(posedge clk) disable iff (rst)
         !mem_we |=> ($stable(wr_addr) && $stable(wr_data));
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write-back outputs moved without a write");
endmodule

// ---- bsctu_pkg.sv ----
// Package of constants and types for the bit set/clear/test unit
package bsctu_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int BIT_W = 3;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [DATA_W-1:0] ONE_HOT_BASE = 8'h01;

   typedef enum logic [2:0] {
      bsctu_no_operation,
      bsctu_bit_clear_op,
      bsctu_bit_set_op,
      bsctu_test_skip_if_zero_op,
      bsctu_test_skip_if_one_op
   } bsctu_op_t;

   typedef enum {
      BSCTU_EXEC,
      BSCTU_SKIP
   } bsctu_state_t;
endpackage

// ---- bsctu_mem.sv ----
// Data memory of 256 bytes with registered read data
`timescale 1ns/1ps
module bsctu_mem (
   input wire logic clk, // Instruction clock
   input wire logic [bsctu_pkg::ADDR_W-1:0] raddr, // Read address
   output logic [bsctu_pkg::DATA_W-1:0] rdata, // Registered read data
   input wire logic we, // Write enable
   input wire logic [bsctu_pkg::ADDR_W-1:0] waddr, // Write address
   input wire logic [bsctu_pkg::DATA_W-1:0] wdata // Write data
);
   // Known start contents keep the byte checks free of unknowns; firmware must still not rely on them
   logic [bsctu_pkg::DATA_W-1:0] mem [0:(1<<bsctu_pkg::ADDR_W)-1] = '{default: bsctu_pkg::DATA_RESET};

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem[raddr];
   end
endmodule

// ---- tb.sv ----
// Self-checking testbench for the bit set/clear/test unit
`timescale 1ns/1ps
module tb;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic instr_valid = 1'h0;
   bsctu_pkg::bsctu_op_t op = bsctu_pkg::bsctu_no_operation;
   logic [7:0] addr = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic instr_done, skip_taken, squashing, wr_en;
   logic [7:0] wr_addr, wr_data;
   int num_errors = 0;
   int comparisons = 0;

   always #25 clk = ~clk;

   bsctu_top u_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .op(op), .addr(addr), .bit_sel(bit_sel),
      .instr_done(instr_done), .skip_taken(skip_taken), .squashing(squashing), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data));

   task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (num_errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ****************************************
   // One instruction slot: accept, execute
   // ****************************************
   task automatic do_op(input bsctu_pkg::bsctu_op_t o, input logic [7:0] a, input logic [2:0] b,
      input logic sk, input logic wr, input logic [7:0] d, input logic cd);
      op = o;
      addr = a;
      bit_sel = b;
      instr_valid = 1'h1;
      @(posedge clk);
      @(negedge clk);
      instr_valid = 1'h0;
      check("instr_done", {7'h00, instr_done}, 8'h01);
      check("skip_taken", {7'h00, skip_taken}, {7'h00, sk});
      @(negedge clk);
      check("squashing", {7'h00, squashing}, {7'h00, sk});
      check("wr_en", {7'h00, wr_en}, {7'h00, wr});
      if (wr) check("wr_addr", wr_addr, a);
      if (wr && cd) check("wr_data", wr_data, d);
   endtask

   // Memory is not reset, so each byte used here (FF, then 00) is cleared bit by bit before its value is trusted
   task automatic t_set_clear();
      for (int i = 0; i < 8; i++) do_op(bsctu_pkg::bsctu_bit_clear_op, 8'hFF, 3'(i), 1'h0, 1'h1, 8'h00, i == 7);
      do_op(bsctu_pkg::bsctu_bit_set_op, 8'hFF, 3'h0, 1'h0, 1'h1, 8'h01, 1'h1);
      do_op(bsctu_pkg::bsctu_bit_set_op, 8'hFF, 3'h2, 1'h0, 1'h1, 8'h05, 1'h1);
      do_op(bsctu_pkg::bsctu_bit_set_op, 8'hFF, 3'h3, 1'h0, 1'h1, 8'h0D, 1'h1);
      do_op(bsctu_pkg::bsctu_bit_set_op, 8'hFF, 3'h7, 1'h0, 1'h1, 8'h8D, 1'h1);
      do_op(bsctu_pkg::bsctu_bit_clear_op, 8'hFF, 3'h2, 1'h0, 1'h1, 8'h89, 1'h1);
      do_op(bsctu_pkg::bsctu_bit_set_op, 8'hFF, 3'h2, 1'h0, 1'h1, 8'h8D, 1'h1);
      for (int i = 0; i < 8; i++) do_op(bsctu_pkg::bsctu_bit_clear_op, 8'h00, 3'(i), 1'h0, 1'h1, 8'h00, i == 7);
      do_op(bsctu_pkg::bsctu_bit_set_op, 8'h00, 3'h7, 1'h0, 1'h1, 8'h80, 1'h1);
      do_op(bsctu_pkg::bsctu_bit_clear_op, 8'h00, 3'h7, 1'h0, 1'h1, 8'h00, 1'h1);
   endtask

   // Byte FF holds 8D here; the squashed slot must leave it untouched
   task automatic t_skip_zero();
      do_op(bsctu_pkg::bsctu_test_skip_if_zero_op, 8'hFF, 3'h1, 1'h1, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_bit_set_op, 8'hFF, 3'h1, 1'h0, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_test_skip_if_zero_op, 8'hFF, 3'h1, 1'h1, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_no_operation, 8'hFF, 3'h0, 1'h0, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_test_skip_if_zero_op, 8'hFF, 3'h0, 1'h0, 1'h0, 8'h00, 1'h0);
   endtask

   task automatic t_skip_one();
      do_op(bsctu_pkg::bsctu_test_skip_if_one_op, 8'hFF, 3'h7, 1'h1, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_bit_clear_op, 8'hFF, 3'h7, 1'h0, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_test_skip_if_one_op, 8'hFF, 3'h7, 1'h1, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_test_skip_if_one_op, 8'hFF, 3'h7, 1'h0, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_test_skip_if_one_op, 8'hFF, 3'h1, 1'h0, 1'h0, 8'h00, 1'h0);
      do_op(bsctu_pkg::bsctu_bit_clear_op, 8'hFF, 3'h7, 1'h0, 1'h1, 8'h0D, 1'h1);
      do_op(bsctu_pkg::bsctu_no_operation, 8'h00, 3'h0, 1'h0, 1'h0, 8'h00, 1'h0);
   endtask

   // Whole run is about 80 cycles; this leaves ample margin
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end

   initial begin
      repeat (10) @(negedge clk);
      check("wr_en", {7'h00, wr_en}, 8'h00);
      check("squashing", {7'h00, squashing}, 8'h00);
      rst = 1'h0;
      t_set_clear();
      t_skip_zero();
      t_skip_one();
      finish_test();
   end
endmodule
